// ---- spi_eeprom_read_interface_tb.sv ----
// Purpose: Self-checking bench: host end reading device end, plus a bench-driven device.
// Assumes: Second device is written and read by bench tasks on its own link.
// Notes: Expected read bytes come from the wire and from earlier reads of the same address.
module spi_eeprom_read_interface_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import spi_rom_pkg::*;
    localparam int WCYC = 400;
    logic sys_clk = 0, rstn = 0, start = 0, pause = 0, rd_ready = 0, so_last = 0;
    logic busy, rd_valid, wip1, wip2, sck_q, hold_ready = 1, pause_en = 0, so2_seen = 0;
    logic [7:0] start_addr = 8'h00, rd_data, sh_in, sh_out, cur_addr, nb, r, a;
    logic [7:0] n_rd = 8'h00, n_wb = 8'h00, shadow [256];
    logic [7:0] wd [2] = '{8'hA5, 8'h3C};
    logic [15:0] byte_count = 16'h0001, lfsr = 16'hDEBF, nbits = 16'h0000;
    logic [15:0] wcnt = 16'h0000;
    logic [7:0] hdr_q [$], rd_q [$];
    bit seen_a [256];
    int n_mismatch = 0, n_compared = 0, pcnt = 0;
    spi_rom_if link1();
    spi_rom_if link2();
    spi_rom_host spi_rom_host_i (.sys_clk(sys_clk), .rstn(rstn), .link(link1.host),
        .start(start), .start_addr(start_addr), .byte_count(byte_count), .pause(pause),
        .busy(busy), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
    spi_rom_device #(.WRITE_CYC(WCYC)) spi_rom_device_i (.sys_clk(sys_clk), .rstn(rstn),
        .link(link1.device), .write_in_progress(wip1));
    spi_rom_device #(.WRITE_CYC(WCYC)) spi_rom_device_i2 (.sys_clk(sys_clk), .rstn(rstn),
        .link(link2.device), .write_in_progress(wip2));
    spi_rom_props spi_rom_props_i (.sys_clk(sys_clk), .rstn(rstn), .sck(link1.sck),
        .cs_n(link1.cs_n), .si(link1.si), .hold_n(link1.hold_n), .so_o(link1.so_o),
        .so_oe(link1.so_oe));
    // Released wire shows the inverse of its last level, never a lucky match
    assign link1.so = link1.so_oe ? link1.so_o : ~so_last;
    assign link2.so = link2.so_o;
    initial forever #5 sys_clk = ~sys_clk;
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp || $isunknown(seen)) begin
            n_mismatch++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    always @(negedge sys_clk) begin
        lfsr <= lfsr_next(lfsr);
        rd_ready <= !hold_ready && lfsr[0];
        pcnt <= (pause_en && lfsr[7:0] == 8'h00) ? 20 : (pcnt > 0 ? pcnt - 1 : 0);
        pause <= (pcnt > 0);
    end
    // Wire monitor: rebuilds bytes MSB first at each link clock rise
    always @(posedge sys_clk) begin
        so_last <= link1.so;
        sck_q <= link1.sck;
        if (wip2) wcnt <= wcnt + 16'h0001;
        if (link2.so_oe) so2_seen <= 1'b1;
        if (link1.cs_n) begin
            nbits = 16'h0000;
        end else if (link1.sck && !sck_q) begin
            sh_in = {sh_in[6:0], link1.si};
            sh_out = {sh_out[6:0], link1.so};
            nbits++;
            if (nbits[2:0] == 3'h0 && nbits <= 16'h0010) begin
                check(sh_in, hdr_q.pop_front());
            end else if (nbits[2:0] == 3'h0) begin
                a = cur_addr + nbits[10:3] - 8'h03;
                if (seen_a[a]) check(sh_out, shadow[a]);
                shadow[a] = sh_out;
                seen_a[a] = 1'b1;
                rd_q.push_back(sh_out);
                n_wb++;
            end
        end
        if (rd_valid && rd_ready) begin
            check(rd_data, rd_q.pop_front());
            n_rd++;
        end
    end
    task automatic host_read(input logic [7:0] sa, input logic [15:0] n);
        logic [7:0] b0;
        logic [7:0] r0;
        b0 = n_wb;
        r0 = n_rd;
        @(negedge sys_clk);
        cur_addr = sa;
        start_addr = sa;
        byte_count = n;
        start = 1;
        hdr_q.push_back(READ_CODE);
        hdr_q.push_back(sa);
        hold_ready = (n > 16'd32);
        @(negedge sys_clk);
        start = 0;
        if (hold_ready) begin
            // Full buffer must park the link clock
            for (int i = 0; i < 5000 && n_wb != b0 + 8'd32; i++) @(negedge sys_clk);
            repeat (100) @(negedge sys_clk);
            nb = n_wb;
            repeat (200) @(negedge sys_clk);
            check(n_wb, nb);
            check({7'h00, rd_valid}, 8'h01);
            hold_ready = 0;
        end
        for (int i = 0; i < 30000 && (busy || rd_valid); i++) @(negedge sys_clk);
        check(n_rd - r0, n[7:0]);
    endtask : host_read
    task automatic spi2(input logic [7:0] b, input int hold_at, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            link2.si = b[i];
            #40 link2.sck = 1;
            q = {q[6:0], link2.so_oe ? link2.so_o : 1'bx};
            #40 link2.sck = 0;
            if (i == hold_at) begin
                #40 link2.hold_n = 0;
                repeat (3) begin
                    #40 link2.sck = 1;
                    link2.si = ~link2.si;
                    #40 link2.sck = 0;
                end
                check({7'h00, link2.so_oe}, 8'h00);
                #40 link2.hold_n = 1;
            end
        end
    endtask : spi2
    initial begin
        link2.sck = 0;
        link2.cs_n = 1;
        link2.si = 0;
        link2.hold_n = 1;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk) rstn = 1;
        pause_en = 1;
        host_read(8'hFE, 16'd4);
        pause_en = 0;
        host_read(8'hF0, 16'd40);
        host_read(8'h00, 16'd1);
        for (int k = 0; k < 2; k++) begin
            link2.cs_n = 0;
            spi2(WRITE_CODE, -1, r);
            spi2(8'hFF + k[7:0], -1, r);
            spi2(wd[k], -1, r);
            #40 link2.cs_n = 1;
            wcnt = 16'h0000;
            #100 check({7'h00, wip2}, 8'h01);
            so2_seen = 0;
            link2.cs_n = 0;
            spi2(READ_CODE, -1, r);
            spi2(8'hFF, -1, r);
            spi2(8'h00, -1, r);
            #40 link2.cs_n = 1;
            check({7'h00, so2_seen}, 8'h00);
            for (int i = 0; i < 2000 && wip2 !== 1'b0; i++) @(negedge sys_clk);
            check({7'h00, wcnt >= 16'(WCYC) && wcnt <= 16'(WCYC + 4)}, 8'h01);
        end
        link2.cs_n = 0;
        spi2(8'h0B, -1, r);
        spi2(8'hFF, -1, r);
        spi2(8'h00, 4, r);
        check(r, wd[0]);
        spi2(8'h00, -1, r);
        check(r, wd[1]);
        #40 link2.cs_n = 1;
        #100 check({7'h00, link2.so_oe}, 8'h00);
        wrap_up;
    end
    initial begin
        #1000000;
        n_mismatch++;
        wrap_up;
    end
endmodule : spi_eeprom_read_interface_tb

// ---- spi_rom_device.sv ----
// Purpose: EEPROM end of the serial link: instruction, address, sequential read.
// Assumes: Link pins are asynchronous to sys_clk and pass a three-stage synchroniser.
// Notes: Writes only load a byte and start the busy timer; codes matching write, or read while not busy, under READ_MASK (0x0B reads) are taken, others ignored.
module spi_rom_device #(
    parameter int WRITE_CYC = spi_rom_pkg::WRITE_CYCLE_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    spi_rom_if.device link,
    output logic write_in_progress
);
    import spi_rom_pkg::*;
    logic [MEM_DEPTH*0+DATA_W-1:0] mem [MEM_DEPTH];
    logic [2:0] sck_s, cs_s, si_s, hold_s;
    logic sck_reg, sck_next, cs_reg, cs_next, si_reg, si_next, hold_reg, hold_next;
    dev_state_t st_reg, st_next;
    logic [7:0] sh_reg, sh_next;
    logic [2:0] bit_reg, bit_next;
    logic [ADDR_W-1:0] ptr_reg, ptr_next;
    logic [DATA_W-1:0] out_reg, out_next;
    logic is_read_reg, is_read_next;
    logic wr_pend_reg, wr_pend_next;
    logic [DATA_W-1:0] wr_data_reg, wr_data_next;
    logic [31:0] busy_reg, busy_next;
    logic so_reg, so_next;
    logic rise, fall, cs_rise, active;
    logic [7:0] shifted;
    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sck_s <= 3'h0;
            cs_s <= 3'h7;
            si_s <= 3'h0;
            hold_s <= 3'h7;
        end else begin
            sck_s <= {sck_s[1:0], link.sck};
            cs_s <= {cs_s[1:0], link.cs_n};
            si_s <= {si_s[1:0], link.si};
            hold_s <= {hold_s[1:0], link.hold_n};
        end
    end
    always_comb begin
        sck_next = (sck_s[1] == sck_s[2]) ? sck_s[2] : sck_reg;
        cs_next = (cs_s[1] == cs_s[2]) ? cs_s[2] : cs_reg;
        si_next = (si_s[1] == si_s[2]) ? si_s[2] : si_reg;
        hold_next = (hold_s[1] == hold_s[2]) ? hold_s[2] : hold_reg;
    end
    always_comb begin
        active = !cs_reg && hold_reg;
        rise = active && sck_next && !sck_reg;
        fall = active && !sck_next && sck_reg;
        cs_rise = cs_next && !cs_reg;
        shifted = {sh_reg[6:0], si_reg};
        st_next = st_reg;
        sh_next = sh_reg;
        bit_next = bit_reg;
        ptr_next = ptr_reg;
        out_next = out_reg;
        is_read_next = is_read_reg;
        wr_pend_next = wr_pend_reg;
        wr_data_next = wr_data_reg;
        so_next = so_reg;
        busy_next = (busy_reg != 32'h0) ? busy_reg - 32'h1 : busy_reg;
        if (cs_reg) begin
            st_next = DEV_INSTR;
            bit_next = 3'h0;
            is_read_next = 1'b0;
        end else begin
            // Hold leaves every field untouched, so release resumes mid-byte
            if (rise) begin
                sh_next = shifted;
                bit_next = bit_reg + 3'h1;
                if (bit_reg == 3'h7) begin
                    case (st_reg)
                        DEV_INSTR: begin
                            if ((shifted & READ_MASK) == READ_CODE && busy_reg == 32'h0) begin
                                st_next = DEV_ADDR;
                                is_read_next = 1'b1;
                            end else if ((shifted & READ_MASK) == WRITE_CODE) begin
                                st_next = DEV_ADDR;
                            end else begin
                                st_next = DEV_IDLE;
                            end
                        end
                        DEV_ADDR: begin
                            ptr_next = shifted;
                            st_next = DEV_DATA;
                            if (is_read_reg) begin
                                out_next = mem[shifted];
                            end
                        end
                        DEV_DATA: begin
                            if (is_read_reg) begin
                                ptr_next = ptr_reg + 8'h01;
                                out_next = mem[ptr_reg + 8'h01];
                            end else begin
                                wr_data_next = shifted;
                                wr_pend_next = 1'b1;
                            end
                        end
                        default: st_next = DEV_IDLE;
                    endcase
                end else if (st_reg == DEV_DATA && !is_read_reg) begin
                    wr_pend_next = 1'b0;
                end
            end
            if (fall && st_reg == DEV_DATA && is_read_reg) begin
                so_next = out_reg[3'h7 - bit_reg];
            end
        end
        if (cs_rise && wr_pend_reg) begin
            wr_pend_next = 1'b0;
            if (busy_reg == 32'h0) begin
                busy_next = 32'(WRITE_CYC);
            end
        end
    end
    // Power-up contents are a fixed pattern so reads are never unknown
    initial begin
        for (int i = 0; i < MEM_DEPTH; i++) begin
            mem[i] = DATA_W'(i * 7 + 3);
        end
    end
    // Only the byte completed just before select rises is programmed
    always @(posedge sys_clk) begin
        if (cs_rise && wr_pend_reg && busy_reg == 32'h0) begin
            mem[ptr_reg] <= wr_data_reg;
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sck_reg <= 1'b0;
            cs_reg <= 1'b1;
            si_reg <= 1'b0;
            hold_reg <= 1'b1;
            st_reg <= DEV_IDLE;
            sh_reg <= 8'h00;
            bit_reg <= 3'h0;
            ptr_reg <= ADDR_RESET;
            out_reg <= 8'h00;
            is_read_reg <= 1'b0;
            wr_pend_reg <= 1'b0;
            wr_data_reg <= 8'h00;
            busy_reg <= 32'h0;
            so_reg <= 1'b0;
        end else begin
            sck_reg <= sck_next;
            cs_reg <= cs_next;
            si_reg <= si_next;
            hold_reg <= hold_next;
            st_reg <= st_next;
            sh_reg <= sh_next;
            bit_reg <= bit_next;
            ptr_reg <= ptr_next;
            out_reg <= out_next;
            is_read_reg <= is_read_next;
            wr_pend_reg <= wr_pend_next;
            wr_data_reg <= wr_data_next;
            busy_reg <= busy_next;
            so_reg <= so_next;
        end
    end
    assign link.so_o = so_reg;
    // Released when deselected, paused or not in a read data phase
    assign link.so_oe = active && st_reg == DEV_DATA && is_read_reg;
    assign write_in_progress = (busy_reg != 32'h0);
endmodule : spi_rom_device

// ---- spi_rom_fifo.sv ----
// Purpose: Parameterised FIFO holding bytes the host end has read.
// Assumes: One clock; valid and ready on both sides.
// Notes: Full and empty come from a count, so both are exact.
module spi_rom_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_next = push ? AW'((wr_reg + 1'b1) % DEPTH) : wr_reg;
        rd_next = pop ? AW'((rd_reg + 1'b1) % DEPTH) : rd_reg;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end
    assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem[rd_reg];
endmodule : spi_rom_fifo

// ---- spi_rom_host.sv ----
// Purpose: Host end: issues a read of N bytes from a start address, queues data.
// Assumes: Link clock is divided from sys_clk; device output passes three stages.
// Notes: FIFO back-pressure parks the link clock low between bytes.
module spi_rom_host #(
    parameter int HALF_DIV = spi_rom_pkg::SCK_HALF_DIV,
    parameter int DEPTH = spi_rom_pkg::FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rstn,
    spi_rom_if.host link,
    input wire logic start,
    input wire logic [spi_rom_pkg::ADDR_W-1:0] start_addr,
    input wire logic [15:0] byte_count,
    input wire logic pause,
    output logic busy,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [spi_rom_pkg::DATA_W-1:0] rd_data
);
    import spi_rom_pkg::*;
    hst_state_t st_reg, st_next;
    logic [7:0] div_reg, div_next;
    logic [5:0] bit_reg, bit_next;
    logic [15:0] left_reg, left_next;
    logic [15:0] tx_reg, tx_next;
    logic [7:0] rx_reg, rx_next;
    logic sck_reg, sck_next, cs_reg, cs_next, si_reg, si_next;
    logic hold_reg, hold_next;
    logic [2:0] so_s;
    logic so_reg, so_next;
    logic push, fifo_ready, tick, in_data_phase;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            so_s <= 3'h0;
        end else begin
            so_s <= {so_s[1:0], link.so};
        end
    end
    always_comb begin
        so_next = (so_s[1] == so_s[2]) ? so_s[2] : so_reg;
        tick = (div_reg == 8'(HALF_DIV - 1));
        in_data_phase = (bit_reg >= 6'd16);
        st_next = st_reg;
        div_next = tick ? 8'h00 : div_reg + 8'h01;
        bit_next = bit_reg;
        left_next = left_reg;
        tx_next = tx_reg;
        rx_next = rx_reg;
        sck_next = sck_reg;
        cs_next = cs_reg;
        si_next = si_reg;
        hold_next = hold_reg;
        push = 1'b0;
        case (st_reg)
            HST_IDLE: begin
                cs_next = 1'b1;
                hold_next = 1'b1;
                if (start && byte_count != 16'h0) begin
                    st_next = HST_LOW;
                    cs_next = 1'b0;
                    tx_next = {READ_CODE, start_addr};
                    si_next = READ_CODE[7];
                    left_next = byte_count;
                    bit_next = 6'd0;
                    div_next = 8'h00;
                end
            end
            HST_LOW: begin
                // Pause only enters with the clock low, so the device never misses a fall
                hold_next = !pause;
                // Clock stays low while paused or when no room remains for a byte
                if (tick && hold_reg && !pause && (!in_data_phase || fifo_ready)) begin
                    sck_next = 1'b1;
                    st_next = HST_HIGH;
                end
            end
            HST_HIGH: begin
                if (tick) begin
                    // Sampled late: the device answers a fall through two synchronisers
                    if (in_data_phase) begin
                        rx_next = {rx_reg[6:0], so_next};
                    end
                    sck_next = 1'b0;
                    bit_next = bit_reg + 6'd1;
                    tx_next = {tx_reg[14:0], 1'b0};
                    si_next = tx_reg[14];
                    st_next = HST_LOW;
                    if (in_data_phase && bit_reg[2:0] == 3'h7) begin
                        push = 1'b1;
                        left_next = left_reg - 16'h1;
                        bit_next = 6'd16;
                        if (left_reg == 16'h1) begin
                            st_next = HST_DONE;
                        end
                    end
                end
            end
            HST_DONE: begin
                hold_next = 1'b1;
                if (tick) begin
                    cs_next = 1'b1;
                    st_next = HST_IDLE;
                end
            end
            default: st_next = HST_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= HST_IDLE;
            div_reg <= 8'h00;
            bit_reg <= 6'd0;
            left_reg <= 16'h0;
            tx_reg <= 16'h0;
            rx_reg <= 8'h00;
            sck_reg <= 1'b0;
            cs_reg <= 1'b1;
            si_reg <= 1'b0;
            so_reg <= 1'b0;
            hold_reg <= 1'b1;
        end else begin
            hold_reg <= hold_next;
            st_reg <= st_next;
            div_reg <= div_next;
            bit_reg <= bit_next;
            left_reg <= left_next;
            tx_reg <= tx_next;
            rx_reg <= rx_next;
            sck_reg <= sck_next;
            cs_reg <= cs_next;
            si_reg <= si_next;
            so_reg <= so_next;
        end
    end
    spi_rom_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) rx_fifo (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data(rx_next),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data)
    );
    assign link.sck = sck_reg;
    assign link.cs_n = cs_reg;
    assign link.si = si_reg;
    assign link.hold_n = hold_reg;
    assign busy = (st_reg != HST_IDLE);
endmodule : spi_rom_host

// ---- spi_rom_if.sv ----
// Purpose: Serial link between the host end and the EEPROM end.
// Assumes: The testbench resolves the serial output wire from its enable on link1; on link2 it is so_o.
// Notes: No clocking block; both ends sample the wires on sys_clk.
interface spi_rom_if;
    logic sck;
    logic cs_n;
    logic si;
    logic hold_n;
    logic so_o;
    logic so_oe;
    logic so;
    modport device (input sck, input cs_n, input si, input hold_n, output so_o, output so_oe);
    modport host (output sck, output cs_n, output si, output hold_n, input so);
endinterface : spi_rom_if

// ---- spi_rom_pkg.sv ----
// Purpose: Shared constants and types for the serial EEPROM read link.
// Assumes: Both ends run on sys_clk at 100 MHz; the link clock is made by the host end.
// Notes: Timing counts derive from printed times and the system clock rate.
package spi_rom_pkg;
    localparam int SYS_CLK_MHZ = 100;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 256;
    localparam logic [7:0] READ_CODE = 8'h03;
    localparam logic [7:0] READ_MASK = 8'hF7;
    localparam logic [7:0] WRITE_CODE = 8'h02;
    localparam int WRITE_CYCLE_MS = 5;
    localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_MS * 1000 * SYS_CLK_MHZ;
    localparam int SCK_HALF_DIV = 4;
    localparam int FIFO_DEPTH = 32;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
    typedef enum logic [3:0] {
        DEV_IDLE = 4'b0001,
        DEV_INSTR = 4'b0010,
        DEV_ADDR = 4'b0100,
        DEV_DATA = 4'b1000
    } dev_state_t;
    typedef enum logic [3:0] {
        HST_IDLE = 4'b0001,
        HST_LOW = 4'b0010,
        HST_HIGH = 4'b0100,
        HST_DONE = 4'b1000
    } hst_state_t;
endpackage : spi_rom_pkg

// ---- spi_rom_props.sv ----
// Purpose: Concurrent checks on the serial link between host end and EEPROM end.
// Assumes: Host makes the link clock with a half period of four sys_clk cycles.
// Notes: Output checks allow a few cycles for the device's synchroniser.
module spi_rom_props (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    input wire logic so_o,
    input wire logic so_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] rises_reg;
    logic [15:0] rises_next;
    logic sck_reg;
    logic sck_next;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    // Counts link clock rises inside one frame
    always_comb begin
        sck_next = sck;
        rises_next = cs_n ? 16'h0000 : rises_reg + {15'h0000, sck & ~sck_reg};
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rises_reg <= 16'h0000;
            sck_reg <= 1'b0;
        end else begin
            rises_reg <= rises_next;
            sck_reg <= sck_next;
        end
    end
    reset_idle_a: assert property ($rose(rstn) |-> cs_n && !sck && !so_oe)
        else $error("link not idle after reset");
    sck_framed_a: assert property (sck |-> !cs_n)
        else $error("link clock high outside a frame");
    cs_fall_a: assert property ($fell(cs_n) |-> !sck)
        else $error("frame opened with link clock high");
    sck_high_a: assert property ($rose(sck) |-> sck [*4])
        else $error("link clock high phase too short");
    sck_low_a: assert property ($fell(sck) |-> !sck [*4])
        else $error("link clock low phase too short");
    si_hold_a: assert property (sck && $past(sck) |-> $stable(si))
        else $error("serial input moved while clock high");
    frame_count_a: assert property ($rose(cs_n) |-> rises_reg >= 16'h0010
        && rises_reg[2:0] == 3'h0)
        else $error("frame not whole bytes after header");
    so_idle_a: assert property (cs_n [*5] |-> !so_oe)
        else $error("output driven while deselected");
    so_pause_a: assert property (!hold_n [*5] |-> !so_oe)
        else $error("output driven while paused");
    so_edge_a: assert property (so_oe && $past(so_oe) && $changed(so_o) |-> !$past(sck, 2))
        else $error("output moved outside the low clock phase");
endmodule : spi_rom_props
